// [core/ctrl_port_pkg.sv]
// Shared constants for the serial control port, both ends.
// Assumes a 10 MHz system clock at each end.
package ctrl_port_pkg;
  localparam int WORD_BITS = 16;
  // Control word layout
  localparam int WD_BIT_POS = 15;
  localparam int MODE_LSB = 12;
  localparam int CFG_LSB = 9;
  // Status word layout
  localparam int FRAME_ERR_POS = 0;
  localparam int CMD_ERR_POS = 1;
  localparam int WAKE_POS = 2;
  localparam int CUR_MODE_LSB = 12;
  // Mode codes
  localparam logic [2:0] MODE_INVALID = 3'h0;
  localparam logic [2:0] MODE_RESTART = 3'h1;
  localparam logic [2:0] MODE_FLASH = 3'h2;
  localparam logic [2:0] MODE_NORMAL = 3'h3;
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_STOP = 3'h5;
  localparam logic [2:0] MODE_FAILSAFE = 3'h6;
  localparam logic [2:0] MODE_READ = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h3;
  // Host register map (byte addresses on Wishbone, byte offsets)
  localparam logic [3:0] REG_TX = 4'h0;
  localparam logic [3:0] REG_RX = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_INT_STAT = 4'h8;
  localparam logic [3:0] REG_INT_CLR = 4'hC;
  localparam logic [3:0] REG_INT_EN = 4'h0;
  // Host link clock half period, in system cycles (800 ns period)
  localparam int SCK_HALF_NS = 400;
  localparam int CLK_NS = 100;
  localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;
endpackage

// [core/ctrl_port_if.sv]
// Four-wire serial link between master and device.
// Resolves the shared data output wire itself, reading the pull-up level when released.
`timescale 1ns/10ps
interface ctrl_port_if;
  logic chip_select_low;
  logic sck;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  wire sdo_line;
  // Released line reads as its pull-up level
  assign sdo_line = sdo_oe ? sdo_o : 1'b1;
  modport device (input chip_select_low, input sck, input sdi,
    output sdo_o, output sdo_oe);
  modport master (output chip_select_low, output sck, output sdi,
    input sdo_line);
endinterface

// [core/ctrl_port_device.sv]
// Device end of the serial control port.
// Assumes link pins are asynchronous to clk_i; samples them twice.
`timescale 1ns/10ps
// Functional notes
// [RULE1] 16-bit word in, 16-bit status out
// [RULE2] Chip select low starts a frame
// [RULE3] Chip select rise adopts a valid word
// [RULE4] Data output released at chip select rise
// [RULE5] Input sampled on falling link clock
// [RULE6] Output advances after rising link clock
// [RULE7] Clock count mismatch discards the word
// [RULE8] Frame error shown in next frame
// [RULE9] Master gives device its own select
// [RULE10] All-zero mode code ignored
// [RULE11] Disallowed mode transitions ignored
// [RULE12] Rejections set command error and interrupt
// [RULE13] Previous output repeated after rejection
// [RULE14] Master alternates watchdog trigger bit; the master sends bit 15 as written to REG_TX and does not toggle it itself
// [RULE15] Wake pin level reported in output
// [RULE16] All-ones mode reads register, no write
// [RULE17] Transmit register loaded at select fall
module ctrl_port_device (
  input wire logic clk_i,
  input wire logic rst_i,
  ctrl_port_if.device link,
  input wire logic wake_input_pin_i,
  input wire logic int_inhibit_i,
  output logic [15:0] control_word_o,
  output logic [2:0] mode_o,
  output logic cmd_error_o,
  output logic int_o
);
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] sdi_sync;
    logic [1:0] wk_sync;
    logic cs_d;
    logic sck_d;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] last_out;
    logic [4:0] count;
    logic frame_err;
    logic cmd_err;
    logic irq;
    logic [15:0] ctrl;
    logic [2:0] mode;
    logic [7:0][15:0] cfg;
    logic sdo;
    logic oe;
    logic rejected;
  } state_s;
  state_s state_reg;
  state_s state_next;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [2:0] req;
  logic [2:0] sel;
  logic [2:0] rd_sel;
  logic allowed;
  logic [15:0] status;
  assign cs_fall = state_reg.cs_d & ~state_reg.cs_sync[1];
  assign cs_rise = ~state_reg.cs_d & state_reg.cs_sync[1];
  assign sck_rise = ~state_reg.sck_d & state_reg.sck_sync[1];
  assign sck_fall = state_reg.sck_d & ~state_reg.sck_sync[1];
  // --------------------------------------------------------------
  // Mode transition check
  // --------------------------------------------------------------
  assign req = state_reg.rx[ctrl_port_pkg::MODE_LSB +: 3];
  assign sel = state_reg.rx[ctrl_port_pkg::CFG_LSB +: 3];
  // Select field complete on the seventh falling link clock
  assign rd_sel = {state_reg.rx[1:0], state_reg.sdi_sync[1]};
  always_comb begin
    allowed = 1'b1;
    if (req == ctrl_port_pkg::MODE_INVALID) begin
      allowed = 1'b0; // RULE10
    end else if (state_reg.mode == ctrl_port_pkg::MODE_STOP &&
        req == ctrl_port_pkg::MODE_FLASH) begin
      allowed = 1'b0; // RULE11
    end else if (req == ctrl_port_pkg::MODE_RESTART &&
        state_reg.mode != ctrl_port_pkg::MODE_FLASH) begin
      allowed = 1'b0; // RULE11
    end
  end
  // Status word presented in the next frame
  always_comb begin
    status = 16'h0000;
    status[ctrl_port_pkg::CUR_MODE_LSB +: 3] = state_reg.mode;
    status[ctrl_port_pkg::FRAME_ERR_POS] = state_reg.frame_err; // RULE8
    status[ctrl_port_pkg::CMD_ERR_POS] = state_reg.cmd_err;
    status[ctrl_port_pkg::WAKE_POS] = state_reg.wk_sync[1]; // RULE15
  end
  // --------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.cs_sync = {state_reg.cs_sync[0], link.chip_select_low};
    state_next.sck_sync = {state_reg.sck_sync[0], link.sck};
    state_next.sdi_sync = {state_reg.sdi_sync[0], link.sdi};
    state_next.wk_sync = {state_reg.wk_sync[0], wake_input_pin_i};
    state_next.cs_d = state_reg.cs_sync[1];
    state_next.sck_d = state_reg.sck_sync[1];
    if (cs_fall) begin // RULE2
      state_next.count = 5'h00;
      state_next.oe = 1'b1;
      // RULE13: the frame after a rejected frame repeats that frame's word
      state_next.tx = state_reg.rejected ? state_reg.last_out : status;
      state_next.tx[ctrl_port_pkg::FRAME_ERR_POS] = state_reg.frame_err; // RULE8
      state_next.sdo = state_next.tx[15]; // RULE17
      state_next.last_out = state_next.tx;
      state_next.rejected = 1'b0;
    end
    if (~state_reg.cs_sync[1] & ~cs_fall) begin
      if (sck_fall) begin
        state_next.rx = {state_reg.rx[14:0], state_reg.sdi_sync[1]}; // RULE5
        state_next.count = 5'((state_reg.count + 5'h01) & 5'h1F);
        if (state_reg.count == 5'h06 &&
            state_reg.rx[4:2] == ctrl_port_pkg::MODE_READ) begin
          // RULE16: selected register fills the rest of this frame
          state_next.tx = {state_reg.tx[15], state_reg.cfg[rd_sel][8:0],
            6'h00};
        end
      end
      if (sck_rise) begin
        state_next.tx = {state_reg.tx[14:0], 1'b0}; // RULE6
        state_next.sdo = state_reg.tx[14];
      end
    end
    if (cs_rise) begin
      state_next.oe = 1'b0; // RULE4
      state_next.frame_err = 1'b0;
      if (state_reg.count != 5'd16) begin // RULE7
        state_next.frame_err = 1'b1; // RULE8
        state_next.cmd_err = 1'b1; // RULE12
        state_next.rejected = 1'b1;
      end else if (!allowed) begin
        state_next.cmd_err = 1'b1; // RULE12
        state_next.rejected = 1'b1;
      end else if (req == ctrl_port_pkg::MODE_READ) begin
        state_next.cmd_err = 1'b0;
      end else begin
        state_next.ctrl = state_reg.rx; // RULE3
        state_next.mode = req;
        state_next.cfg[sel] = state_reg.rx;
        state_next.cmd_err = 1'b0;
      end
      if (state_next.rejected && !int_inhibit_i) begin
        state_next.irq = 1'b1; // RULE12
      end else if (state_reg.count == 5'd16 && allowed) begin
        state_next.irq = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.cs_sync <= 2'h3;
      state_reg.cs_d <= 1'b1;
      state_reg.mode <= ctrl_port_pkg::MODE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end
  assign link.sdo_o = state_reg.sdo;
  assign link.sdo_oe = state_reg.oe;
  assign control_word_o = state_reg.ctrl;
  assign mode_o = state_reg.mode;
  assign cmd_error_o = state_reg.cmd_err;
  assign int_o = state_reg.irq;
endmodule

// [core/ctrl_port_master.sv]
// Master end: Wishbone slave that runs 16-bit frames on the link.
// Assumes sdo_line is asynchronous; samples it twice.
`timescale 1ns/10ps
module ctrl_port_master (
  input wire logic clk_i,
  input wire logic rst_i,
  ctrl_port_if.master link,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic int_o
);
  typedef enum logic [1:0] {IDLE, LOW, HIGH, DONE} phase_e;
  typedef struct packed {
    phase_e phase;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [4:0] bits;
    logic [3:0] div;
    logic [1:0] sdo_sync;
    logic cs_n;
    logic sck;
    logic busy;
    logic done_st;
    logic done_en;
    logic ack;
    logic [31:0] rdata;
  } state_s;
  state_s state_reg;
  state_s state_next;
  logic acc;
  assign acc = cyc_i & stb_i & ~state_reg.ack;
  always_comb begin
    state_next = state_reg;
    state_next.sdo_sync = {state_reg.sdo_sync[0], link.sdo_line};
    state_next.ack = acc;
    state_next.rdata = 32'h0000_0000;
    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    if (acc && we_i) begin
      if (adr_i == ctrl_port_pkg::REG_TX && !state_reg.busy) begin
        state_next.tx = dat_i[15:0]; // RULE14
        state_next.busy = 1'b1;
        state_next.phase = LOW;
        state_next.cs_n = 1'b0; // RULE2
        state_next.bits = 5'h00;
        state_next.div = 4'h0;
      end else if (adr_i == ctrl_port_pkg::REG_INT_CLR) begin
        state_next.done_st = state_reg.done_st & ~dat_i[0];
      end else if (adr_i == ctrl_port_pkg::REG_STAT) begin
        state_next.done_en = dat_i[0];
      end
    end else if (acc) begin
      if (adr_i == ctrl_port_pkg::REG_RX) begin
        state_next.rdata = {16'h0000, state_reg.rx};
      end else if (adr_i == ctrl_port_pkg::REG_STAT) begin
        state_next.rdata = {29'h0, state_reg.done_en,
          state_reg.done_st, state_reg.busy};
      end
    end
    // ------------------------------------------------------------
    // Frame timing: link clock idles high, falls then rises
    // ------------------------------------------------------------
    if (state_reg.phase != IDLE) begin
      state_next.div = 4'(state_reg.div + 4'h1);
      if (state_reg.div == 4'(ctrl_port_pkg::SCK_HALF_CYC - 1)) begin
        state_next.div = 4'h0;
        unique case (state_reg.phase)
          LOW: begin
            if (state_reg.bits == 5'd16) begin
              state_next.phase = DONE;
            end else begin
              state_next.sck = 1'b0;
              state_next.phase = HIGH;
            end
          end
          HIGH: begin
            state_next.sck = 1'b1; // RULE6
            state_next.rx = {state_reg.rx[14:0], state_reg.sdo_sync[1]};
            state_next.tx = {state_reg.tx[14:0], 1'b0};
            state_next.bits = 5'(state_reg.bits + 5'h01);
            state_next.phase = LOW;
          end
          DONE: begin
            state_next.cs_n = 1'b1; // RULE9
            state_next.busy = 1'b0;
            state_next.done_st = 1'b1;
            state_next.phase = IDLE;
          end
          default: state_next.phase = IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.cs_n <= 1'b1;
      state_reg.sck <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end
  assign link.chip_select_low = state_reg.cs_n;
  assign link.sck = state_reg.sck;
  assign link.sdi = state_reg.tx[15]; // RULE1
  assign dat_o = state_reg.rdata;
  assign ack_o = state_reg.ack;
  assign int_o = state_reg.done_st & state_reg.done_en;
endmodule

// [verification/ctrl_port_link_sva.sv]
// Checker for the serial link between master and device ends.
// Assumes the link is clocked from the master end's clk_i domain.
`timescale 1ns/10ps
module ctrl_port_link_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chip_select_low,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] falls_reg;
  logic [3:0] since_reg;
  // ----------------------------------------
  // Link clock bookkeeping
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      falls_reg <= 5'h00;
    end else if ($fell(chip_select_low)) begin
      falls_reg <= {4'h0, $fell(sck)};
    end else if ($fell(sck) && !chip_select_low) begin
      falls_reg <= falls_reg + 5'h01;
    end
    if (rst_i || $rose(sck) || $fell(chip_select_low)) begin
      since_reg <= 4'h0;
    end else if (since_reg != 4'hF) begin
      since_reg <= since_reg + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_frame_len;
    $rose(chip_select_low) |-> falls_reg == 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad count");
  property p_sck_low;
    $fell(sck) |-> !sck [*4] ##1 sck;
  endproperty
  a_sck_low: assert property (p_sck_low) else $error("bad low");
  property p_sck_idle;
    chip_select_low |-> sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck idle");
  property p_cs_hold;
    $fell(chip_select_low) |-> !chip_select_low [*8];
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("short cs");
  property p_drive;
    $fell(chip_select_low) |-> ##[1:4] sdo_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("no drive");
  property p_release;
    $rose(chip_select_low) |-> ##[1:5] !sdo_oe;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_idle_off;
    chip_select_low [*6] |-> !sdo_oe;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle drive");
  property p_sdo_step;
    !chip_select_low && sdo_oe && $past(sdo_oe) && $changed(sdo_o)
      |-> since_reg <= 4'h5;
  endproperty
  a_sdo_step: assert property (p_sdo_step) else $error("late shift");
  c_data: cover property (!chip_select_low && sdi);
endmodule

// [verification/sbc_spi_control_port_tb.sv]
// Bench: Wishbone master drives one end, a hand link drives a spare device.
// Assumes the link ends elaborate with their default parameters.
`timescale 1ns/10ps
module sbc_spi_control_port_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wake = 1'b0;
  logic inhib = 1'b0;
  logic [31:0] rdat;
  logic [31:0] got;
  logic ack, m_int, d_int, cmd_err, err2;
  logic [15:0] cw, cw2, rx, keep;
  logic [2:0] mode;
  int miscompares = 0;
  int samples_checked = 0;
  ctrl_port_if lk();
  ctrl_port_if lk2();
  ctrl_port_master i_ctrl_port_master (.clk_i(clk_i), .rst_i(rst_i),
    .link(lk.master), .adr_i(adr), .dat_i(wdat), .sel_i(4'hF), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack), .int_o(m_int));
  ctrl_port_device i_ctrl_port_device (.clk_i(clk_i), .rst_i(rst_i),
    .link(lk.device), .wake_input_pin_i(wake), .int_inhibit_i(inhib),
    .control_word_o(cw), .mode_o(mode), .cmd_error_o(cmd_err), .int_o(d_int));
  ctrl_port_device i_ctrl_port_device_2 (.clk_i(clk_i), .rst_i(rst_i),
    .link(lk2.device), .wake_input_pin_i(wake), .int_inhibit_i(inhib),
    .control_word_o(cw2), .mode_o(), .cmd_error_o(err2), .int_o());
  ctrl_port_link_sva i_sva (.clk_i(clk_i), .rst_i(rst_i),
    .chip_select_low(lk.chip_select_low), .sck(lk.sck), .sdi(lk.sdi),
    .sdo_o(lk.sdo_o), .sdo_oe(lk.sdo_oe));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [15:0] mk(input logic wd, input logic [2:0] m);
    return {wd, m, 3'h4, 9'h000};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    // Read data taken at the edge that sees ack high
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic frame(input logic [15:0] w);
    wb(ctrl_port_pkg::REG_TX, 1'b1, {16'h0, w});
    do begin
      wb(ctrl_port_pkg::REG_STAT, 1'b0, 32'h0);
    end while (got[0] !== 1'b0);
    wb(ctrl_port_pkg::REG_RX, 1'b0, 32'h0);
    rx = got[15:0];
    repeat (6) @(posedge clk_i);
  endtask
  task automatic bang(input int n, input logic [15:0] w);
    lk2.chip_select_low <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      lk2.sck <= 1'b0;
      lk2.sdi <= w[15-i];
      repeat (4) @(posedge clk_i);
      rx[15-i] = lk2.sdo_line;
      lk2.sck <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    lk2.chip_select_low <= 1'b1;
    lk2.sdi <= ~w[16-n];
    repeat (8) @(posedge clk_i);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reject;
    do_reset;
    wb(ctrl_port_pkg::REG_STAT, 1'b1, 32'h1);
    wake <= 1'b1;
    frame(mk(1'b1, ctrl_port_pkg::MODE_STOP));
    chk(cw, mk(1'b1, ctrl_port_pkg::MODE_STOP));
    chk(rx[2], 1'h1);
    chk(m_int, 1'h1);
    wb(ctrl_port_pkg::REG_INT_CLR, 1'b1, 32'h1);
    chk(m_int, 1'h0);
    wake <= 1'b0;
    frame(mk(1'b0, ctrl_port_pkg::MODE_FLASH));
    chk(mode, ctrl_port_pkg::MODE_STOP);
    chk({cmd_err, d_int}, 2'h3);
    chk(rx[2], 1'h0);
    keep = rx;
    frame(mk(1'b1, ctrl_port_pkg::MODE_INVALID));
    chk(rx, keep);
    chk(cw, mk(1'b1, ctrl_port_pkg::MODE_STOP));
    wb(ctrl_port_pkg::REG_STAT, 1'b1, 32'h0);
    frame(mk(1'b0, ctrl_port_pkg::MODE_READ));
    chk(m_int, 1'h0);
    do_reset;
    keep = cw;
    inhib <= 1'b1;
    frame(mk(1'b1, ctrl_port_pkg::MODE_READ));
    chk(cw, keep);
    chk(mode, ctrl_port_pkg::MODE_NORMAL);
    frame(mk(1'b0, ctrl_port_pkg::MODE_INVALID));
    chk({cmd_err, d_int}, 2'h2);
    inhib <= 1'b0;
  endtask
  task automatic t_modes;
    int m;
    for (int i = 0; i < 5; i++) begin
      m = (i + 2) % 5 + 1;
      do_reset;
      frame(mk(1'b1, 3'(m)));
      chk(mode, (m == 1) ? ctrl_port_pkg::MODE_NORMAL : 3'(m));
    end
    frame(mk(1'b0, ctrl_port_pkg::MODE_RESTART));
    chk(mode, ctrl_port_pkg::MODE_RESTART);
  endtask
  task automatic t_count;
    do_reset;
    keep = cw2;
    bang(15, mk(1'b1, ctrl_port_pkg::MODE_STOP));
    chk(cw2, keep);
    chk(err2, 1'h1);
    bang(16, mk(1'b1, ctrl_port_pkg::MODE_STOP));
    chk(rx[0], 1'h1);
    chk(cw2, mk(1'b1, ctrl_port_pkg::MODE_STOP));
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    summarize;
  end
  initial begin
    lk2.chip_select_low = 1'b1;
    lk2.sck = 1'b1;
    lk2.sdi = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reject;
    t_modes;
    t_count;
    summarize;
  end
endmodule
